// [spi_port.sv]
// Purpose: Serial peripheral port, master or slave, at the pins
// Assumes: Configuration ports change only while the port is idle
// Notes:   Slave shifting runs on the incoming serial clock
`timescale 1ns/1ps
`default_nettype none
module spi_port
   import spi_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // Serial clock pin, also the slave link clock
   input  wire logic       serial_clock_pin,
   output logic            serial_clock_out,
   output logic            serial_clock_oe,
   // Select and data pins
   input  wire logic       slave_select_in,
   input  wire logic       mosi_in,
   output logic            mosi_out,
   output logic            mosi_oe,
   input  wire logic       miso_in,
   output logic            miso_out,
   output logic            miso_oe,
   // Configuration
   input  wire logic       master_mode,
   input  wire logic       clk_polarity,
   input  wire logic       clk_phase,
   input  wire logic       miso_open_drain_enable,
   input  wire logic       miso_output_disable,
   // Straps
   input  wire logic [1:0] boot_mode_select_pins,
   input  wire logic [1:0] clock_ratio_select_pins,
   output logic [1:0]      boot_mode,
   output logic            core_clk_from_pll,
   // Transmit words
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   output logic            tx_ready,
   // Receive words
   output logic [7:0]      rx_data,
   output logic            rx_valid,
   input  wire logic       rx_ready,
   // Status
   output logic            busy,
   output logic            mm_error,
   output logic            rx_overflow,
   input  wire logic       status_clear
);
   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic       ss_s1;
   logic       ss_s2;
   logic       miso_s1;
   logic       miso_s2;
   logic [1:0] boot_s1;
   logic [1:0] boot_s2;
   logic [1:0] ratio_s1;
   logic [1:0] ratio_s2;
   logic [1:0] strap_cnt;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ss_s1    <= 1'b1;
         ss_s2    <= 1'b1;
         miso_s1  <= 1'b1;
         miso_s2  <= 1'b1;
         boot_s1  <= BOOT_MODE_RESET;
         boot_s2  <= BOOT_MODE_RESET;
         ratio_s1 <= CLK_RATIO_BYPASS;
         ratio_s2 <= CLK_RATIO_BYPASS;
      end else begin
         ss_s1    <= slave_select_in;
         ss_s2    <= ss_s1;
         miso_s1  <= miso_in;
         miso_s2  <= miso_s1;
         boot_s1  <= boot_mode_select_pins;
         boot_s2  <= boot_s1;
         ratio_s1 <= clock_ratio_select_pins;
         ratio_s2 <= ratio_s1;
      end
   end

   // Straps are caught once after release, never by the reset itself
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         strap_cnt         <= 2'h0;
         boot_mode         <= BOOT_MODE_RESET;
         core_clk_from_pll <= 1'b0;
      end else begin
         if (strap_cnt != STRAP_DONE) begin
            strap_cnt <= strap_cnt + 2'h1;
         end
         if (strap_cnt == STRAP_CAPTURE) begin
            boot_mode         <= boot_s2;
            core_clk_from_pll <= (ratio_s2 != CLK_RATIO_BYPASS);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Slave link domain
   // Inverting the pin clock turns all four formats into one
   wire        slave_clk    = serial_clock_pin ^ clk_polarity ^ clk_phase;
   wire        slave_sel    = ~master_mode & ~slave_select_in;
   wire        slave_arst_n = rstn & slave_sel;
   logic [2:0] s_cnt;
   logic [6:0] s_rx;
   logic [7:0] s_word;
   logic       s_tgl;
   logic       s_out;
   logic       s_launched;
   logic [7:0] slave_tx_word;

   always_ff @(posedge slave_clk or negedge slave_arst_n) begin
      if (!slave_arst_n) begin
         s_cnt <= 3'h0;
         s_rx  <= 7'h00;
      end else begin
         s_cnt <= s_cnt + 3'h1;
         s_rx  <= {s_rx[5:0], mosi_in};
      end
   end

   // Kept apart so a deselect cannot fake a finished word
   always_ff @(posedge slave_clk or negedge rstn) begin
      if (!rstn) begin
         s_word <= WORD_RESET;
         s_tgl  <= 1'b0;
      end else if (slave_sel && s_cnt == 3'h7) begin
         s_word <= {s_rx, mosi_in};
         s_tgl  <= ~s_tgl;
      end
   end

   always_ff @(negedge slave_clk or negedge slave_arst_n) begin
      if (!slave_arst_n) begin
         s_out      <= 1'b1;
         s_launched <= 1'b0;
      end else begin
         s_out      <= slave_tx_word[~s_cnt];
         s_launched <= 1'b1;
      end
   end

   // First bit of phase zero must stand before any edge
   wire miso_bit   = (~clk_phase & ~s_launched) ? slave_tx_word[7] : s_out;
   wire miso_drive = slave_sel & ~miso_output_disable;

   assign miso_out = miso_bit & ~miso_open_drain_enable;
   assign miso_oe  = miso_drive & (~miso_open_drain_enable | ~miso_bit);

   ////////////////////////////////////////////////////////////////////////////
   // Word events back into the core domain
   logic t_s1;
   logic t_s2;
   logic t_s3;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         t_s1 <= 1'b0;
         t_s2 <= 1'b0;
         t_s3 <= 1'b0;
      end else begin
         t_s1 <= s_tgl;
         t_s2 <= t_s1;
         t_s3 <= t_s2;
      end
   end

   // The word holds for eight more serial clocks, ample for the toggle
   wire slave_evt = t_s2 ^ t_s3;

   ////////////////////////////////////////////////////////////////////////////
   // Master engine
   m_state_e   state;
   m_state_e   next_state;
   logic [2:0] div;
   logic [4:0] e_cnt;
   logic [7:0] m_tx;
   logic [7:0] m_rx;
   logic       fifo_ready;

   wire tx_take     = tx_valid & tx_ready;
   wire m_start     = tx_take & master_mode;
   wire mm_hit      = master_mode & ~ss_s2;
   wire half_tick   = (state == M_RUN) && (div == HALF_LAST);
   wire sample_tick = half_tick && (e_cnt[0] == clk_phase);
   wire launch_tick = half_tick && (e_cnt[0] != clk_phase) && (e_cnt != 5'h00);
   wire last_edge   = half_tick && (e_cnt == EDGE_LAST);
   wire m_push      = (state == M_DONE);
   wire push_valid  = m_push | slave_evt;
   wire [7:0] push_data = m_push ? m_rx : s_word;
   // Slave words cannot be stalled, so a full FIFO loses them
   wire overflow_hit = slave_evt & ~fifo_ready;
   wire next_idle    = (next_state == M_IDLE);
   wire next_tx_ready = master_mode ? (next_idle & fifo_ready & ss_s2 & ~mm_error)
                                    : ss_s2;

   always_comb begin
      next_state = state;
      case (state)
         M_IDLE: begin
            if (m_start && !mm_hit) begin
               next_state = M_RUN;
            end
         end
         M_RUN: begin
            if (mm_hit) begin
               next_state = M_IDLE;
            end else if (last_edge) begin
               next_state = M_DONE;
            end
         end
         M_DONE: begin
            next_state = M_IDLE;
         end
         default: begin
            next_state = M_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= M_IDLE;
         div   <= 3'h0;
         e_cnt <= 5'h00;
      end else begin
         state <= next_state;
         div   <= (state != M_RUN || half_tick) ? 3'h0 : div + 3'h1;
         if (state != M_RUN) begin
            e_cnt <= 5'h00;
         end else if (half_tick) begin
            e_cnt <= e_cnt + 5'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         m_tx <= WORD_RESET;
         m_rx <= WORD_RESET;
      end else if (m_start) begin
         m_tx <= tx_data;
         m_rx <= WORD_RESET;
      end else begin
         if (launch_tick) begin
            m_tx <= {m_tx[6:0], 1'b0};
         end
         if (sample_tick) begin
            m_rx <= {m_rx[6:0], miso_s2};
         end
      end
   end

   assign mosi_out = m_tx[7];

   // Pin drivers, released whenever the master is not mid word
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         serial_clock_out <= 1'b0;
         serial_clock_oe  <= 1'b0;
         mosi_oe          <= 1'b0;
      end else begin
         if (state != M_RUN) begin
            serial_clock_out <= clk_polarity;
         end else if (half_tick) begin
            serial_clock_out <= ~serial_clock_out;
         end
         serial_clock_oe <= master_mode & ~next_idle;
         mosi_oe         <= master_mode & ~next_idle;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Received words and status
   always_ff @(posedge clk) begin
      if (tx_take && !master_mode) begin
         slave_tx_word <= tx_data;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_ready    <= 1'b0;
         busy        <= 1'b0;
         mm_error    <= 1'b0;
         rx_overflow <= 1'b0;
      end else begin
         tx_ready    <= next_tx_ready;
         busy        <= ~next_idle;
         mm_error    <= mm_hit | (mm_error & ~status_clear);
         rx_overflow <= overflow_hit | (rx_overflow & ~status_clear);
      end
   end

   spi_fifo #(
      .WIDTH (WORD_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rstn      (rstn),
      .in_valid  (push_valid),
      .in_ready  (fifo_ready),
      .in_data   (push_data),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (rx_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   logic       sclk_last;
   logic [4:0] edge_seen;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sclk_last <= 1'b0;
         edge_seen <= 5'h00;
      end else begin
         sclk_last <= serial_clock_out;
         if (state == M_IDLE) begin
            edge_seen <= 5'h00;
         end else if (serial_clock_out != sclk_last) begin
            edge_seen <= edge_seen + 5'h01;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_word_end;
      state == M_RUN ##1 state == M_DONE;
   endsequence

   sequence s_idle_steady;
      (state == M_IDLE && $stable(clk_polarity))[*2];
   endsequence

   AST_BIT_CLOCKS: assert property (s_word_end |=> edge_seen == EDGE_COUNT)
      else $error("Master word did not carry one clock per bit");
   AST_GATED_CLOCK: assert property (s_idle_steady |-> serial_clock_out == clk_polarity)
      else $error("Serial clock left its idle level outside a word");
   AST_SLAVE_QUIET: assert property (ss_s2[*4] |-> !slave_evt)
      else $error("Slave word finished while deselected");
   AST_SAMPLE_HOLD: assert property (sample_tick |=> $stable(mosi_out))
      else $error("Master data moved on its sample edge");
   AST_MM_ERROR: assert property (mm_hit |=> mm_error && state == M_IDLE)
      else $error("Multimaster error not flagged or transfer not stopped");
   AST_MASTER_DRIVE: assert property (state == M_RUN |-> mosi_oe && serial_clock_oe && !miso_oe)
      else $error("Master pin directions wrong during a word");
   AST_SLAVE_DIR: assert property ((!master_mode)[*2] |-> !mosi_oe && !serial_clock_oe)
      else $error("Slave drove its receive lines");
   AST_OPEN_DRAIN: assert property (miso_open_drain_enable |-> !(miso_oe && miso_out))
      else $error("Open drain MISO driven high");
   AST_MISO_DISABLE: assert property (miso_output_disable |-> !miso_oe)
      else $error("MISO driven while disabled");
   AST_IDLE_FLOAT: assert property (state == M_IDLE ##1 state == M_IDLE |-> !mosi_oe)
      else $error("MOSI driven while idle");
endmodule
`default_nettype wire

// [spi_pkg.sv]
// Purpose: Shared constants for the serial peripheral port
// Assumes: Core clock of 40 MHz
// Notes:   Word length and FIFO depth are fixed
package spi_pkg;
   localparam int WORD_BITS = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int CLK_PERIOD_NS = 25;
   // Least half period of the master serial clock
   localparam int HALF_PERIOD_NS = 100;
   localparam int HALF_CYCLES = (HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] HALF_LAST = 3'(HALF_CYCLES - 1);
   localparam logic [4:0] EDGE_COUNT = 5'(2 * WORD_BITS);
   localparam logic [4:0] EDGE_LAST = 5'(2 * WORD_BITS - 1);
   // Straps are taken once the pin synchroniser has settled
   localparam logic [1:0] STRAP_CAPTURE = 2'h2;
   localparam logic [1:0] STRAP_DONE = 2'h3;
   localparam logic [1:0] CLK_RATIO_BYPASS = 2'h0;
   localparam logic [1:0] BOOT_MODE_RESET = 2'h0;
   localparam logic [7:0] WORD_RESET = 8'h00;
   typedef enum logic [1:0] {
      M_IDLE = 2'b00,
      M_RUN  = 2'b01,
      M_DONE = 2'b11
   } m_state_e;
endpackage

// [spi_fifo.sv]
// Purpose: Word FIFO with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Read data is the head word, shown while out_valid
`timescale 1ns/1ps
`default_nettype none
module spi_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;

   wire  do_push = in_valid & in_ready;
   wire  do_pop  = out_valid & out_ready;
   wire  full    = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);

   assign in_ready  = ~full;
   assign out_valid = (wr_ptr != rd_ptr);
   assign out_data  = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (do_push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// [spi_far_end.sv]
// Purpose: Far side of the link, slave or master
// Assumes: Pins resolved with pull-ups outside
// Notes:   Master frames run at 32 ns per bit
`timescale 1ns/1ps
`default_nettype none
module spi_far_end (
   // Pins seen
   input  wire logic sclk,
   input  wire logic mosi,
   input  wire logic miso,
   input  wire logic sel_n,
   // Pins driven
   output logic      sclk_drv,
   output logic      sclk_oe,
   output logic      mosi_drv,
   output logic      mosi_oe,
   output logic      miso_drv,
   output logic      miso_oe,
   output logic      ss_n,
   // Format
   input  wire logic cpol,
   input  wire logic cpha
);
   logic [7:0] tx_word;
   logic [7:0] rx_word;
   logic [7:0] sh;
   logic [3:0] cnt;
   // Released line falls back to its pull-up
   assign miso_oe = !sel_n;
   initial begin
      {sclk_drv, sclk_oe, mosi_drv, mosi_oe, miso_drv, ss_n} = 6'h01;
      tx_word = 8'h00;
      rx_word = 8'h00;
      sh = 8'h00;
      cnt = 4'h0;
   end
   ////////////////////////////////////////
   // Slave; stray sampling edges after the word are ignored
   always @(negedge sel_n) begin
      sh = tx_word;
      cnt = 4'h0;
      if (!cpha) begin
         miso_drv = sh[7];
         sh = sh << 1;
      end
   end
   always @(sclk) begin
      if (!sel_n && ((sclk != cpol) ^ cpha)) begin
         if (cnt < 4'h8) begin
            rx_word = {rx_word[6:0], mosi};
            cnt = cnt + 4'h1;
         end
      end else if (!sel_n) begin
         miso_drv = sh[7];
         sh = sh << 1;
      end
   end
   ////////////////////////////////////////
   // Master; clock stands still outside frames
   task automatic frame(input logic [7:0] w, input logic sel);
      sh = w;
      sclk_drv = cpol;
      sclk_oe = 1'b1;
      mosi_oe = 1'b1;
      #16;
      ss_n = !sel;
      if (!cpha) begin
         mosi_drv = sh[7];
         sh = sh << 1;
      end
      for (int e = 0; e < 16; e++) begin
         #16;
         if ((e % 2 == 0) ^ cpha) rx_word = {rx_word[6:0], miso};
         sclk_drv = !sclk_drv;
         if ((e % 2 == 1) ^ cpha) begin
            mosi_drv = sh[7];
            sh = sh << 1;
         end
      end
      #16;
      {ss_n, sclk_oe, mosi_oe} = 3'h4;
   endtask
endmodule
`default_nettype wire

// [testbench.sv]
// Purpose: Self-checking bench for the serial port
// Assumes: Pull-ups on clock and data lines
// Notes:   Far side is spi_far_end
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk, rstn, sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe;
   logic        master_mode, cpol, cpha, od, dis, tx_valid, tx_ready, rx_valid, rx_ready;
   logic        busy, mm_error, rx_overflow, status_clear, pll, mm_ss_n, far_sel_n;
   logic        f_sclk, f_sclk_oe, f_mosi, f_mosi_oe, f_miso, f_miso_oe, f_ss_n;
   logic [1:0]  boot_pins, ratio_pins, boot_mode;
   logic [7:0]  tx_data, rx_data, tw, fw;
   logic [17:0] rows [4];
   int          num_errors, checks_done, edges;
   wire         sclk_w, mosi_w, miso_w, dut_ss;
   assign sclk_w = sclk_oe ? sclk_out : (f_sclk_oe ? f_sclk : 1'b1);
   assign mosi_w = mosi_oe ? mosi_out : (f_mosi_oe ? f_mosi : 1'b1);
   assign miso_w = miso_oe ? miso_out : (f_miso_oe ? f_miso : 1'b1);
   assign dut_ss = master_mode ? mm_ss_n : f_ss_n;
   spi_port uut (
      .clk(clk), .rstn(rstn), .serial_clock_pin(sclk_w), .serial_clock_out(sclk_out),
      .serial_clock_oe(sclk_oe), .slave_select_in(dut_ss), .mosi_in(mosi_w),
      .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
      .miso_oe(miso_oe), .master_mode(master_mode), .clk_polarity(cpol), .clk_phase(cpha),
      .miso_open_drain_enable(od), .miso_output_disable(dis),
      .boot_mode_select_pins(boot_pins), .clock_ratio_select_pins(ratio_pins),
      .boot_mode(boot_mode), .core_clk_from_pll(pll), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .busy(busy), .mm_error(mm_error), .rx_overflow(rx_overflow),
      .status_clear(status_clear)
   );
   spi_far_end far (
      .sclk(sclk_w), .mosi(mosi_w), .miso(miso_w), .sel_n(far_sel_n), .sclk_drv(f_sclk),
      .sclk_oe(f_sclk_oe), .mosi_drv(f_mosi), .mosi_oe(f_mosi_oe), .miso_drv(f_miso),
      .miso_oe(f_miso_oe), .ss_n(f_ss_n), .cpol(cpol), .cpha(cpha)
   );
   initial clk = 1'b0;
   always #12.5 clk = !clk;
   ////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("Checks %0d, errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic timeout(input int n);
      if (n >= 400) begin
         num_errors++;
         give_verdict;
      end
   endtask
   task automatic push(input logic [7:0] w);
      int n;
      n = 0;
      @(negedge clk);
      tx_data = w;
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      tx_valid = 1'b0;
      timeout(n);
   endtask
   task automatic wait_rx;
      int n;
      n = 0;
      @(negedge clk);
      while (rx_valid !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      timeout(n);
   endtask
   task automatic pop;
      rx_ready = 1'b1;
      @(negedge clk);
      rx_ready = 1'b0;
   endtask
   task automatic do_reset;
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      chk({5'h00, sclk_oe, mosi_oe, miso_oe}, 8'h00);
      rstn = 1'b1;
      repeat (5) @(negedge clk);
   endtask
   ////////////////////////////////////////
   // Clock edges seen only while the port drives the pin
   always @(sclk_w) if (!far_sel_n && sclk_oe === 1'b1) edges++;
   always @(negedge clk) begin
      if (od === 1'b1 && miso_oe === 1'b1) chk({7'h00, miso_out}, 8'h00);
      if (dis === 1'b1) chk({7'h00, miso_oe}, 8'h00);
   end
   ////////////////////////////////////////
   initial begin
      rows = '{18'h0_a53c, 18'h1_8001, 18'h2_7ffe, 18'h3_c396};
      {master_mode, cpol, cpha, od, dis, tx_valid, rx_ready} = 7'h00;
      {status_clear, mm_ss_n, far_sel_n} = 3'h3;
      {boot_pins, ratio_pins, tx_data} = 12'h900;
      num_errors = 0;
      checks_done = 0;
      edges = 0;
      do_reset;
      chk({5'h00, boot_mode, pll}, 8'h05);
      far.frame(8'h33, 1'b0);
      repeat (8) @(negedge clk);
      chk({7'h00, rx_valid}, 8'h00);
      for (int r = 0; r < 4; r++) begin
         {cpol, cpha, tw, fw} = rows[r];
         master_mode = 1'b1;
         far.tx_word = fw;
         push(tw);
         @(negedge clk);
         far_sel_n = 1'b0;
         edges = 0;
         chk({6'h00, miso_oe, mosi_oe}, 8'h01);
         wait_rx;
         chk(8'(edges), 8'h10);
         chk(far.rx_word, tw);
         chk(rx_data, fw);
         pop;
         chk({5'h00, mm_error, sclk_out, mosi_oe}, {6'h00, cpol, 1'b0});
         far_sel_n = 1'b1;
         master_mode = 1'b0;
         repeat (3) @(negedge clk);
         push(tw);
         far.frame(fw, 1'b1);
         wait_rx;
         chk(far.rx_word, tw);
         chk(rx_data, fw);
         pop;
      end
      od = 1'b1;
      push(8'hc5);
      far.frame(8'h0f, 1'b1);
      wait_rx;
      chk(far.rx_word, 8'hc5);
      pop;
      {od, dis} = 2'h1;
      push(8'h96);
      far.frame(8'h12, 1'b1);
      wait_rx;
      chk(far.rx_word, 8'hff);
      chk(rx_data, 8'h12);
      pop;
      dis = 1'b0;
      // Second master shows up mid word
      master_mode = 1'b1;
      push(8'h55);
      repeat (6) @(negedge clk);
      mm_ss_n = 1'b0;
      repeat (4) @(negedge clk);
      chk({5'h00, mm_error, busy, mosi_oe}, 8'h04);
      chk({7'h00, tx_ready}, 8'h00);
      mm_ss_n = 1'b1;
      // Select must clear both sync stages, or the set wins over the clear
      repeat (2) @(negedge clk);
      status_clear = 1'b1;
      @(negedge clk);
      status_clear = 1'b0;
      @(negedge clk);
      chk({7'h00, mm_error}, 8'h00);
      // Fill the receive buffer until it refuses, then drain it
      far_sel_n = 1'b0;
      for (int k = 0; k < 8; k++) push(8'(k));
      repeat (80) @(negedge clk);
      chk({6'h00, tx_ready, rx_valid}, 8'h01);
      // A slave word against a full buffer is lost and flagged
      {master_mode, far_sel_n} = 2'h1;
      repeat (2) @(negedge clk);
      far.frame(8'h5a, 1'b1);
      repeat (8) @(negedge clk);
      chk({7'h00, rx_overflow}, 8'h01);
      rx_ready = 1'b1;
      repeat (8) @(negedge clk);
      rx_ready = 1'b0;
      chk({7'h00, rx_valid}, 8'h00);
      status_clear = 1'b1;
      @(negedge clk);
      status_clear = 1'b0;
      chk({6'h00, rx_overflow, mm_error}, 8'h00);
      {boot_pins, ratio_pins} = 4'h4;
      do_reset;
      chk({5'h00, boot_mode, pll}, 8'h02);
      give_verdict;
   end
endmodule
`default_nettype wire
